// [hw/psrd_decode.v]
// decode and execute of the hyper-state and privileged-state reads
//
// Notes on behaviour
// - hyper read selector picks one hyper register
// - clean hyper read writes value to destination
// - hyper trap state banked, indexed by trap_level
// - nonzero bits 13:0 raise illegal instruction
// - hyper selectors 2, 4, 7..30 are illegal
// - hyper read outside hyper mode is illegal
// - hyper trap state read at level zero illegal
// - privileged selector maps 0..14 and 16
// - trap pc/npc/type/state banked by trap_level
// - privileged selectors 15, 17..31 are illegal
// - privileged selectors 0..3 at level zero illegal
// - nonprivileged privileged read gives privileged opcode
//
// The register addresses and the Avalon-MM slave port were chosen for this implementation.
`include "psrd_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module psrd_decode #(
  parameter XLEN = 64,
  parameter TLW = 3,
  parameter max_trap_depth = 6
) (
  input wire clk, // core clock
  input wire rst, // synchronous reset, active high
  input wire inst_valid, // decoded word valid, one cycle
  input wire [31:0] inst, // instruction word
  input wire priv_flag, // privileged mode
  input wire hyper_priv_flag, // hyperprivileged mode
  input wire [TLW-1:0] trap_level, // current trap level
  input wire [XLEN-1:0] hyper_status, // hyper state inputs
  input wire [max_trap_depth*XLEN-1:0] hyper_trap_state, // level 1 lowest
  input wire [XLEN-1:0] hyper_int_pending,
  input wire [XLEN-1:0] hyper_trap_base,
  input wire [XLEN-1:0] hyper_version,
  input wire [XLEN-1:0] hyper_systick_compare,
  input wire [max_trap_depth*XLEN-1:0] trap_pc, // banked, level 1 lowest
  input wire [max_trap_depth*XLEN-1:0] trap_npc,
  input wire [max_trap_depth*XLEN-1:0] trap_state,
  input wire [max_trap_depth*XLEN-1:0] trap_type,
  input wire [XLEN-1:0] tick, // privileged state inputs
  input wire [XLEN-1:0] trap_base,
  input wire [XLEN-1:0] proc_state,
  input wire [XLEN-1:0] int_level,
  input wire [XLEN-1:0] window_ptr,
  input wire [XLEN-1:0] windows_savable,
  input wire [XLEN-1:0] windows_restorable,
  input wire [XLEN-1:0] clean_windows,
  input wire [XLEN-1:0] other_windows,
  input wire [XLEN-1:0] window_state,
  input wire [XLEN-1:0] global_level,
  output reg rd_we, // destination write pulse
  output reg [4:0] rd_addr, // destination register
  output reg [XLEN-1:0] rd_data, // destination value
  output reg exc_illegal, // illegal instruction pulse
  output reg exc_priv_opcode, // privileged opcode pulse
  input wire [3:0] avs_address, // avalon byte address
  input wire avs_read, // avalon read
  input wire avs_write, // avalon write
  input wire [31:0] avs_writedata, // avalon write data
  output reg [31:0] avs_readdata, // avalon read data
  output reg avs_waitrequest, // avalon wait
  output reg irq // level interrupt
);

  // pick the copy of a banked register for the current level
  function [XLEN-1:0] bank_sel;
    input [max_trap_depth*XLEN-1:0] bank;
    input [TLW-1:0] lvl;
    integer k;
    begin
      bank_sel = {XLEN{1'b0}};
      for (k = 0; k < max_trap_depth; k = k + 1) begin
        // level zero matches no copy and reads zero
        if (lvl == k + 1) begin
          bank_sel = bank[k*XLEN +: XLEN];
        end
      end
    end
  endfunction

  // true when the word is a state read with the given op3
  function op_match;
    input [31:0] word;
    input [5:0] code;
    begin
      op_match = word[`PSRD_FMT_HI:`PSRD_FMT_LO] == `PSRD_FMT_VAL &&
        word[`PSRD_OP3_HI:`PSRD_OP3_LO] == code;
    end
  endfunction

  // instruction fields
  wire [4:0] dst = inst[`PSRD_RD_HI:`PSRD_RD_LO];
  wire [4:0] sel = inst[`PSRD_SEL_HI:`PSRD_SEL_LO];
  wire low_bits_set = |inst[`PSRD_ZERO_HI:`PSRD_ZERO_LO];

  // opcode match, gated by the valid pulse
  wire is_hyper = inst_valid && op_match(inst, `PSRD_OP3_HYPER);
  wire is_priv = inst_valid && op_match(inst, `PSRD_OP3_PRIV);

  // level zero leaves the banked registers without a copy
  wire lvl_zero = (trap_level == {TLW{1'b0}});

  // hyper selector decode
  reg [XLEN-1:0] hyper_val;
  reg hyper_sel_ok;
  always @* begin
    hyper_sel_ok = 1'b1;
    hyper_val = {XLEN{1'b0}};
    case (sel)
      `PSRD_H_STATUS: begin
        hyper_val = hyper_status;
      end
      `PSRD_H_TSTATE: begin
        hyper_val = bank_sel(hyper_trap_state, trap_level);
      end
      `PSRD_H_INTP: begin
        hyper_val = hyper_int_pending;
      end
      `PSRD_H_TBASE: begin
        hyper_val = hyper_trap_base;
      end
      `PSRD_H_VER: begin
        hyper_val = hyper_version;
      end
      `PSRD_H_STCMP: begin
        hyper_val = hyper_systick_compare;
      end
      default: begin
        hyper_sel_ok = 1'b0;
      end
    endcase
  end

  // privileged selector decode
  reg [XLEN-1:0] priv_val;
  reg priv_sel_ok;
  always @* begin
    priv_sel_ok = 1'b1;
    priv_val = {XLEN{1'b0}};
    case (sel)
      `PSRD_P_TPC: begin
        priv_val = bank_sel(trap_pc, trap_level);
      end
      `PSRD_P_TNPC: begin
        priv_val = bank_sel(trap_npc, trap_level);
      end
      `PSRD_P_TSTATE: begin
        priv_val = bank_sel(trap_state, trap_level);
      end
      `PSRD_P_TTYPE: begin
        priv_val = bank_sel(trap_type, trap_level);
      end
      `PSRD_P_TICK: begin
        priv_val = tick;
      end
      `PSRD_P_TBASE: begin
        priv_val = trap_base;
      end
      `PSRD_P_PSTATE: begin
        priv_val = proc_state;
      end
      `PSRD_P_TLEVEL: begin
        priv_val = {{(XLEN-TLW){1'b0}}, trap_level};
      end
      `PSRD_P_ILEVEL: begin
        priv_val = int_level;
      end
      `PSRD_P_WPTR: begin
        priv_val = window_ptr;
      end
      `PSRD_P_WSAV: begin
        priv_val = windows_savable;
      end
      `PSRD_P_WRES: begin
        priv_val = windows_restorable;
      end
      `PSRD_P_WCLEAN: begin
        priv_val = clean_windows;
      end
      `PSRD_P_WOTHER: begin
        priv_val = other_windows;
      end
      `PSRD_P_WSTATE: begin
        priv_val = window_state;
      end
      `PSRD_P_GLEVEL: begin
        priv_val = global_level;
      end
      default: begin
        priv_sel_ok = 1'b0;
      end
    endcase
  end

  // hyper read causes of an illegal instruction
  wire hyper_low = is_hyper && low_bits_set;
  wire hyper_resv = is_hyper && !hyper_sel_ok;
  wire hyper_mode = is_hyper && !hyper_priv_flag;
  wire hyper_lvl = is_hyper && sel == `PSRD_H_TSTATE && lvl_zero;
  wire hyper_ill = hyper_low | hyper_resv | hyper_mode | hyper_lvl;

  // privileged read causes; privileged opcode displaces them all
  wire any_priv = priv_flag | hyper_priv_flag;
  wire priv_op = is_priv && !any_priv;
  wire priv_low = is_priv && any_priv && low_bits_set;
  wire priv_resv = is_priv && any_priv && !priv_sel_ok;
  wire priv_lvl = is_priv && any_priv &&
    sel <= `PSRD_P_BANK_MAX && lvl_zero;
  wire priv_ill = priv_low | priv_resv | priv_lvl;

  // a read with no exception goes to the destination
  wire hyper_ok = is_hyper && !hyper_ill;
  wire priv_ok = is_priv && any_priv && !priv_ill;
  wire good_read = hyper_ok | priv_ok;

  // destination write pulse, one cycle after the word
  always @(posedge clk) begin
    if (rst) begin
      rd_we <= 1'b0;
    end else begin
      rd_we <= good_read;
    end
  end

  // illegal instruction pulse
  always @(posedge clk) begin
    if (rst) begin
      exc_illegal <= 1'b0;
    end else begin
      exc_illegal <= hyper_ill | priv_ill;
    end
  end

  // privileged opcode pulse
  always @(posedge clk) begin
    if (rst) begin
      exc_priv_opcode <= 1'b0;
    end else begin
      exc_priv_opcode <= priv_op;
    end
  end

  // destination and value hold until the next good read
  always @(posedge clk) begin
    if (rst) begin
      rd_addr <= 5'h00;
      rd_data <= {XLEN{1'b0}};
    end else if (good_read) begin
      rd_addr <= dst;
      rd_data <= hyper_ok ? hyper_val : priv_val;
    end
  end

  // status, mask and last word seen
  reg [2:0] status;
  reg [2:0] mask;
  reg [7:0] last_inst; // kind pair and selector seen last

  // events that set the sticky status bits
  wire [2:0] events = {priv_op, hyper_ill | priv_ill, good_read};

  // avalon access qualifiers
  wire bus_hit = avs_read | avs_write;
  wire bus_done = bus_hit && !avs_waitrequest;
  wire wr_stat = avs_write && bus_done && avs_address == `PSRD_A_STATUS;
  wire wr_mask = avs_write && bus_done && avs_address == `PSRD_A_MASK;
  wire [2:0] clr_bits = wr_stat ? avs_writedata[2:0] : 3'h0;

  // read mux; unmapped offsets read zero
  reg [31:0] next_readdata;
  always @* begin
    next_readdata = 32'h0;
    case (avs_address)
      `PSRD_A_STATUS: begin
        next_readdata = {29'h0, status};
      end
      `PSRD_A_MASK: begin
        next_readdata = {29'h0, mask};
      end
      `PSRD_A_LAST: begin
        next_readdata = {24'h0, last_inst};
      end
      default: begin
        next_readdata = 32'h0;
      end
    endcase
  end

  // sticky status; an event in the clear cycle wins
  always @(posedge clk) begin
    if (rst) begin
      status <= 3'h0;
    end else begin
      status <= (status & ~clr_bits) | events;
    end
  end

  // interrupt mask
  always @(posedge clk) begin
    if (rst) begin
      mask <= 3'h0;
    end else if (wr_mask) begin
      mask <= avs_writedata[2:0];
    end
  end

  // kind and selector of the last state read seen
  always @(posedge clk) begin
    if (rst) begin
      last_inst <= 8'h00;
    end else if (is_hyper | is_priv) begin
      last_inst <= {1'b0, is_priv, is_hyper, sel};
    end
  end

  // one wait state per access, high again after completion
  always @(posedge clk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !(bus_hit && avs_waitrequest);
    end
  end

  // read data loaded in the wait cycle, stands when wait drops
  always @(posedge clk) begin
    if (rst) begin
      avs_readdata <= 32'h0;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= next_readdata;
    end
  end

  // level interrupt while an unmasked status bit is set
  always @(posedge clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & mask);
    end
  end

endmodule // psrd_decode
`default_nettype wire

// [inc/psrd_defs.vh]
// constants for the privileged state read decoder
`ifndef PSRD_DEFS_VH
`define PSRD_DEFS_VH
// instruction fields
`define PSRD_FMT_HI 31
`define PSRD_FMT_LO 30
`define PSRD_FMT_VAL 2'h2
`define PSRD_RD_HI 29
`define PSRD_RD_LO 25
`define PSRD_OP3_HI 24
`define PSRD_OP3_LO 19
`define PSRD_SEL_HI 18
`define PSRD_SEL_LO 14
`define PSRD_ZERO_HI 13
`define PSRD_ZERO_LO 0
`define PSRD_OP3_HYPER 6'h29
`define PSRD_OP3_PRIV 6'h2a
// hyper selectors
`define PSRD_H_STATUS 5'h00
`define PSRD_H_TSTATE 5'h01
`define PSRD_H_INTP 5'h03
`define PSRD_H_TBASE 5'h05
`define PSRD_H_VER 5'h06
`define PSRD_H_STCMP 5'h1f
// privileged selectors
`define PSRD_P_TPC 5'h00
`define PSRD_P_TNPC 5'h01
`define PSRD_P_TSTATE 5'h02
`define PSRD_P_TTYPE 5'h03
`define PSRD_P_TICK 5'h04
`define PSRD_P_TBASE 5'h05
`define PSRD_P_PSTATE 5'h06
`define PSRD_P_TLEVEL 5'h07
`define PSRD_P_ILEVEL 5'h08
`define PSRD_P_WPTR 5'h09
`define PSRD_P_WSAV 5'h0a
`define PSRD_P_WRES 5'h0b
`define PSRD_P_WCLEAN 5'h0c
`define PSRD_P_WOTHER 5'h0d
`define PSRD_P_WSTATE 5'h0e
`define PSRD_P_FQ 5'h0f
`define PSRD_P_GLEVEL 5'h10
`define PSRD_P_BANK_MAX 5'h03
// avalon register offsets (byte addresses)
`define PSRD_A_STATUS 4'h0
`define PSRD_A_MASK 4'h4
`define PSRD_A_LAST 4'h8
// status bit positions
`define PSRD_S_DONE 0
`define PSRD_S_ILL 1
`define PSRD_S_PRIV 2
`endif

// [testbench/psrd_checker.sv]
// assertions on the decoder ports
`timescale 1ns/1ps
`default_nettype none
module psrd_checker #(parameter TLW = 3) (
  input wire clk, rst, inst_valid, priv_flag, hyper_priv_flag, // inputs
  input wire [31:0] inst, // word
  input wire [TLW-1:0] trap_level, // level
  input wire rd_we, exc_illegal, exc_priv_opcode, // results
  input wire [4:0] rd_addr // destination
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // word fields and mode terms
  wire [4:0] sel = inst[18:14];
  wire hv = inst_valid & inst[31:30] == 2'h2 & inst[24:19] == 6'h29;
  wire pv = inst_valid & inst[31:30] == 2'h2 & inst[24:19] == 6'h2a;
  wire any = priv_flag | hyper_priv_flag;
  wire lz = inst[13:0] == 14'h0;
  wire tz = trap_level == 0;
  wire hok = sel inside {0, 1, 3, 5, 6, 31};
  sequence hyp_ok;
    hv && hyper_priv_flag && lz && hok && !(sel == 1 && tz);
  endsequence
  sequence dest_write;
    rd_we && !exc_illegal && rd_addr == $past(inst[29:25]);
  endsequence
  hyp_write_a: assert property (hyp_ok |=> dest_write)
    else $error("good read not written");
  low_bits_a: assert property (
    (hv | pv) & any & !lz |=> exc_illegal) else $error("low bits taken");
  hyp_resv_a: assert property (hv & !hok |=> exc_illegal)
    else $error("reserved hyper selector taken");
  hyp_mode_a: assert property (hv & !hyper_priv_flag |=> exc_illegal)
    else $error("hyper read outside mode");
  hyp_tl0_a: assert property (hv & sel == 1 & tz |=> exc_illegal)
    else $error("hyper trap state at level zero");
  priv_resv_a: assert property (
    pv & any & (sel == 15 | sel > 16) |=> exc_illegal) else $error("resv");
  priv_tl0_a: assert property (
    pv & any & sel < 4 & tz |=> exc_illegal) else $error("level zero read");
  nonpriv_op_a: assert property (
    pv & !any |=> exc_priv_opcode & !exc_illegal & !rd_we)
    else $error("privileged opcode missing");
endmodule // psrd_checker
`default_nettype wire

// [testbench/psrd_decode_tb.sv]
// self-checking bench for the privileged state read decoder
`timescale 1ns/1ps
`default_nettype none
module psrd_decode_tb;
  logic clk = 0, rst = 1, inst_valid = 0, priv_flag = 0;
  logic hyper_priv_flag = 0, avs_read = 0, avs_write = 0;
  logic [2:0] trap_level = 0;
  logic [3:0] avs_address = 0;
  logic [31:0] inst = 0, avs_writedata = 0, q;
  wire logic rd_we, exc_illegal, exc_priv_opcode, avs_waitrequest, irq;
  wire logic [4:0] rd_addr;
  wire logic [31:0] avs_readdata;
  wire logic [63:0] rd_data, hyper_status, hyper_int_pending, hyper_trap_base,
    hyper_version, hyper_systick_compare, tick, trap_base, proc_state,
    int_level, window_ptr, windows_savable, windows_restorable,
    clean_windows, other_windows, window_state, global_level;
  wire logic [383:0] hyper_trap_state, trap_pc, trap_npc, trap_state,
    trap_type;
  int error_cnt = 0, cmp_count = 0;
  always #5 clk = ~clk;
  psrd_state_model sm (.*);
  psrd_decode dut (.*);
  task cmp(string nm, logic [63:0] e, s);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask
  function automatic logic [63:0] ev(logic h, logic [4:0] s, logic [2:0] l);
    return {8'hc3, 40'h0, l, h, 7'h0, s};
  endfunction
  // one word in, outcome judged one cycle later
  task ins(logic [5:0] op, logic [4:0] s, logic [13:0] lo, int k,
    logic [63:0] e);
    @(posedge clk);
    inst_valid <= 1;
    inst <= {2'h2, ~s, op, s, lo};
    @(posedge clk);
    inst_valid <= 0;
    #1 cmp("kind", 3'h1 << k, {exc_priv_opcode, exc_illegal, rd_we});
    if (k == 0) cmp("data", e, rd_data);
    if (k == 0) cmp("dest", {~s}, rd_addr);
  endtask
  // bus cycle held until waitrequest is seen low
  task av(logic w, logic [3:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {avs_write, avs_read, avs_address, avs_writedata} <= {w, !w, a, d};
    do begin @(posedge clk); n++; end
      while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    {avs_write, avs_read} <= 2'h0;
    if (n >= 20) begin error_cnt++; tally_and_finish; end
  endtask
  task t_hyper;
    {priv_flag, hyper_priv_flag, trap_level} <= 5'he;
    for (int s = 0; s < 32; s++) ins(6'h29, s, 0, (s inside {0, 1, 3, 5,
      6, 31}) ? 0 : 1, ev(1, s, s == 1 ? 6 : 0));
  endtask
  task t_priv;
    {priv_flag, hyper_priv_flag, trap_level} <= 5'h11;
    for (int s = 0; s < 32; s++) ins(6'h2a, s, 0, (s < 15 || s == 16) ? 0
      : 1, s == 7 ? 64'h1 : ev(0, s, s < 4));
  endtask
  task t_guard;
    {priv_flag, hyper_priv_flag, trap_level} <= 5'h8;
    ins(6'h29, 1, 0, 1, 0);
    for (int s = 0; s < 4; s++) ins(6'h2a, s, 0, 1, 0);
    ins(6'h29, 0, 14'h2000, 1, 0);
    ins(6'h2a, 7, 14'h1, 1, 0);
    {priv_flag, hyper_priv_flag} <= 2'h2;
    ins(6'h29, 0, 0, 1, 0);
    priv_flag <= 0;
    ins(6'h2a, 0, 0, 2, 0);
    ins(6'h2a, 15, 1, 2, 0);
  endtask
  task t_irq;
    hyper_priv_flag <= 1;
    av(1, 4'h0, 32'h7);
    av(1, 4'h4, 32'h2);
    av(0, 4'h4, 0);
    cmp("mask", 2, q);
    ins(6'h2a, 31, 0, 1, 0);
    repeat (2) @(posedge clk);
    #1 cmp("irq", 1, irq);
    av(0, 4'h0, 0);
    cmp("status", 2, q);
    av(1, 4'h0, 32'h2);
    av(1, 4'h4, 32'h0);
    ins(6'h2a, 31, 0, 1, 0);
    repeat (2) @(posedge clk);
    #1 cmp("masked irq", 0, irq);
    av(0, 4'h8, 0);
    cmp("last", 8'h5f, q);
    av(0, 4'hc, 0);
    cmp("unmapped", 0, q);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 0;
    t_hyper;
    t_priv;
    t_guard;
    t_irq;
    tally_and_finish;
  end
  task tally_and_finish;
    if (error_cnt == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
endmodule // psrd_decode_tb
bind psrd_decode psrd_checker #(.TLW(TLW)) chk (.*);
`default_nettype wire

// [testbench/psrd_state_model.sv]
// state register model on the far side of the decoder
`timescale 1ns/1ps
`default_nettype none
module psrd_state_model (
  output logic [63:0] hyper_status, hyper_int_pending, hyper_trap_base,
    hyper_version, hyper_systick_compare, tick, trap_base, proc_state,
    int_level, window_ptr, windows_savable, windows_restorable,
    clean_windows, other_windows, window_state, global_level, // plain
  output logic [383:0] hyper_trap_state, trap_pc, trap_npc, trap_state,
    trap_type // banked, level 1 lowest
);
  // value unique to register and level
  function automatic logic [63:0] v(logic h, logic [4:0] s, logic [2:0] l);
    return {8'hc3, 40'h0, l, h, 7'h0, s};
  endfunction
  // every register shows its own pattern
  always_comb begin
    {hyper_status, hyper_int_pending, hyper_trap_base, hyper_version,
      hyper_systick_compare} = {v(1,0,0), v(1,3,0), v(1,5,0), v(1,6,0),
      v(1,31,0)};
    {tick, trap_base, proc_state, int_level, window_ptr, windows_savable,
      windows_restorable, clean_windows, other_windows, window_state,
      global_level} = {v(0,4,0), v(0,5,0), v(0,6,0), v(0,8,0), v(0,9,0),
      v(0,10,0), v(0,11,0), v(0,12,0), v(0,13,0), v(0,14,0), v(0,16,0)};
    for (int i = 0; i < 6; i++) begin
      hyper_trap_state[i*64 +: 64] = v(1, 1, i + 1);
      trap_pc[i*64 +: 64] = v(0, 0, i + 1);
      trap_npc[i*64 +: 64] = v(0, 1, i + 1);
      trap_state[i*64 +: 64] = v(0, 2, i + 1);
      trap_type[i*64 +: 64] = v(0, 3, i + 1);
    end
  end
endmodule // psrd_state_model
`default_nettype wire
